// ### verilog/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    // ==================================================
    // register offsets
    localparam logic [7:0] ADDR_OUTPUT_MODE = 8'h01;
    localparam logic [7:0] ADDR_EXTRA_FEATURES = 8'h03;
    localparam logic [7:0] ADDR_LOWBAT_THR_WIN = 8'h04;
    localparam logic [7:0] ADDR_LOWBAT_CURRENT = 8'h05;
    localparam logic [7:0] ADDR_LED_ONE_FLASH = 8'h06;
    localparam logic [7:0] ADDR_LED_ONE_TORCH = 8'h08;
    localparam logic [7:0] ADDR_LED_TWO_FLASH = 8'h09;
    localparam logic [7:0] ADDR_LED_TWO_TORCH = 8'h0B;
    localparam logic [7:0] ADDR_FAULT_INFO = 8'h0C;
    localparam logic [7:0] ADDR_LED_ONE_ACTUAL = 8'h0D;
    localparam logic [7:0] ADDR_LED_TWO_ACTUAL = 8'h0E;
    localparam logic [7:0] ADDR_LED_ENABLES = 8'h0F;

    // ==================================================
    // reset values
    localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] RST_EXTRA_FEATURES = 8'h88;
    localparam logic [7:0] RST_LOWBAT_THR_WIN = 8'h18;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ==================================================
    // field positions
    localparam int MODE_LSB = 0;
    localparam int DC_EN_BIT = 0;
    localparam int DC_LEVEL_LSB = 1;
    localparam int FOLDBACK_BIT = 4;
    localparam int THRESHOLD_LSB = 0;
    localparam int WINDOW_LSB = 3;
    localparam int CURRENT_LSB = 0;
    localparam int DC_FLAG_BIT = 0;
    localparam int LED_ONE_EN_BIT = 0;
    localparam int LED_TWO_EN_BIT = 1;
    localparam int CUR_W = 6;
    localparam int MS_W = 4;

    // ==================================================
    // operating modes
    typedef enum logic [2:0] {
        MODE_STANDBY = 3'b000,
        MODE_FIXED_5V = 3'b001,
        MODE_ASSIST = 3'b010,
        MODE_FLASH = 3'b011,
        MODE_TRIG_TIMEOUT = 3'b100,
        MODE_TRIG_NO_TIMEOUT = 3'b101,
        MODE_FIXED_5V_TORCH = 3'b110,
        MODE_RESERVED = 3'b111
    } mode_t;

    typedef enum logic [1:0] {
        WIN_DISABLED = 2'b00,
        WIN_1MS = 2'b01,
        WIN_2MS = 2'b10,
        WIN_5MS = 2'b11
    } window_t;

    localparam logic [2:0] THRESHOLD_OFF = 3'b000;
    localparam logic [MS_W-1:0] WIN_1MS_COUNT = 4'h1;
    localparam logic [MS_W-1:0] WIN_2MS_COUNT = 4'h2;
    localparam logic [MS_W-1:0] WIN_5MS_COUNT = 4'h5;

    // low level of current used in the 5 v modes, arbitrary small code
    localparam logic [CUR_W-1:0] LOW_LEVEL_CODE = 6'h02;
    localparam logic [CUR_W-1:0] CUR_ZERO = 6'h00;
    localparam logic [CUR_W-1:0] CUR_ONE = 6'h01;

    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS_DEFAULT = MS_NS / CLK_PERIOD_NS;
    localparam int SOFT_START_NS = 600000;
    localparam int RAMP_STEPS = 64;
    localparam int RAMP_STEP_CYC = SOFT_START_NS / CLK_PERIOD_NS / RAMP_STEPS;
    localparam int RAMP_W = 10;
    localparam logic [RAMP_W-1:0] RAMP_STEP_LAST = RAMP_W'(RAMP_STEP_CYC - 1);
    localparam int SYNC_W = 4;
endpackage

// ### verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import flash_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins
    input wire logic [SYNC_W-1:0] pin_in,
    output logic [SYNC_W-1:0] pin_out
);
    // ==================================================
    // three-stage capture per pin
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            logic s1, s2, s3;
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    pin_out[i] <= 1'b0;
                end else begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    // accept only once two late stages agree
                    if (s2 == s3) begin
                        pin_out[i] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ms_timer
    import flash_ctrl_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic restart,
    // elapsed whole milliseconds, saturating
    output logic [MS_W-1:0] ms_count
);
    localparam logic [31:0] LAST = 32'(CYC_PER_MS - 1);
    logic [31:0] cyc;
    wire ms_tick = (cyc == LAST);
    wire ms_full = (ms_count == {MS_W{1'b1}});

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc <= '0;
            ms_count <= '0;
        end else if (restart) begin
            cyc <= '0;
            ms_count <= '0;
        end else begin
            cyc <= ms_tick ? '0 : cyc + 32'd1;
            if (ms_tick && !ms_full) begin
                ms_count <= ms_count + MS_W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/flash_boost_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module flash_boost_mode_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int CYC_PER_MS = CYC_PER_MS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port from the serial front end
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // flash sequencer, same clock
    input wire logic flash_active,
    // pins and analog comparators
    input wire logic torch_pin,
    input wire logic low_battery_cmp,
    input wire logic dc_limit_cmp,
    input wire logic vin_near_boosted_output_rail_cmp,
    // converter and current source controls
    output logic regulate_5v,
    output logic boost_enable,
    output logic low_frequency,
    output logic [CUR_W-1:0] led_one_current,
    output logic [CUR_W-1:0] led_two_current,
    output logic [2:0] low_battery_threshold,
    output logic dc_limit_enable,
    output logic [2:0] dc_limit_level
);
    // ==================================================
    // registers
    logic [7:0] output_mode_control;
    logic [7:0] extra_features_control;
    logic [7:0] low_battery_threshold_window;
    logic [7:0] low_battery_current_level;
    logic [7:0] led_one_flash_current;
    logic [7:0] led_one_torch_current;
    logic [7:0] led_two_flash_current;
    logic [7:0] led_two_torch_current;
    logic [7:0] fault_information;
    logic [7:0] led_one_actual_current;
    logic [7:0] led_two_actual_current;
    logic [7:0] led_output_enables;

    // ==================================================
    // pin capture and window timer
    logic [SYNC_W-1:0] pins;
    logic [MS_W-1:0] ms_count;
    logic flash_prev;
    wire flash_start = flash_active && !flash_prev;

    pin_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({vin_near_boosted_output_rail_cmp, dc_limit_cmp, low_battery_cmp, torch_pin}),
        .pin_out(pins)
    );

    ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .restart(flash_start),
        .ms_count(ms_count)
    );

    wire torch_level = pins[0];
    wire low_battery = pins[1];
    wire over_limit = pins[2];
    wire vin_near = pins[3];

    // ==================================================
    // field decode
    wire [2:0] mode_field = output_mode_control[MODE_LSB +: 3];
    wire foldback_en = extra_features_control[FOLDBACK_BIT];
    wire dc_en = extra_features_control[DC_EN_BIT];
    wire [2:0] dc_level = extra_features_control[DC_LEVEL_LSB +: 3];
    wire [2:0] threshold = low_battery_threshold_window[THRESHOLD_LSB +: 3];
    wire [1:0] window = low_battery_threshold_window[WINDOW_LSB +: 2];
    wire [CUR_W-1:0] lowbat_level = low_battery_current_level[CURRENT_LSB +: CUR_W];
    wire led_one_en = led_output_enables[LED_ONE_EN_BIT];
    wire led_two_en = led_output_enables[LED_TWO_EN_BIT];

    function automatic logic window_open(input logic [1:0] code, input logic [MS_W-1:0] ms);
        case (code)
            WIN_DISABLED: window_open = 1'b1;
            WIN_1MS: window_open = ms < WIN_1MS_COUNT;
            WIN_2MS: window_open = ms < WIN_2MS_COUNT;
            default: window_open = ms < WIN_5MS_COUNT;
        endcase
    endfunction

    function automatic logic [CUR_W-1:0] ramp_up(input logic [CUR_W-1:0] cur,
                                                 input logic [CUR_W-1:0] target);
        ramp_up = (cur < target) ? cur + CUR_ONE : target;
    endfunction

    // ==================================================
    // mode behaviour
    wire mode_5v = (mode_field == MODE_FIXED_5V) || (mode_field == MODE_FIXED_5V_TORCH);
    // threshold code zero disables the comparator path entirely
    wire lowbat_armed = (threshold != THRESHOLD_OFF);
    wire lowbat_hit = flash_active && lowbat_armed && low_battery
                      && window_open(window, ms_count);

    // ==================================================
    // flash ramp with dc limit
    logic lowbat_latched;
    logic clamped;
    logic [RAMP_W-1:0] ramp_div;
    logic [CUR_W-1:0] ramp_one;
    logic [CUR_W-1:0] ramp_two;
    wire ramp_tick = (ramp_div == RAMP_STEP_LAST);
    wire limit_trip = flash_active && dc_en && over_limit && !clamped;
    wire [CUR_W-1:0] target_one = lowbat_latched ? lowbat_level
                                  : led_one_flash_current[CURRENT_LSB +: CUR_W];
    wire [CUR_W-1:0] target_two = lowbat_latched ? lowbat_level
                                  : led_two_flash_current[CURRENT_LSB +: CUR_W];
    // a reduced target drops immediately, it is never ramped down
    wire [CUR_W-1:0] next_ramp_one = (ramp_one > target_one) ? target_one
                                     : (ramp_tick && !clamped) ? ramp_up(ramp_one, target_one)
                                     : ramp_one;
    wire [CUR_W-1:0] next_ramp_two = (ramp_two > target_two) ? target_two
                                     : (ramp_tick && !clamped) ? ramp_up(ramp_two, target_two)
                                     : ramp_two;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flash_prev <= 1'b0;
            lowbat_latched <= 1'b0;
            clamped <= 1'b0;
            ramp_div <= '0;
            ramp_one <= CUR_ZERO;
            ramp_two <= CUR_ZERO;
        end else begin
            flash_prev <= flash_active;
            if (!flash_active) begin
                lowbat_latched <= 1'b0;
                clamped <= 1'b0;
                ramp_div <= '0;
                ramp_one <= CUR_ZERO;
                ramp_two <= CUR_ZERO;
            end else begin
                if (lowbat_hit) begin
                    lowbat_latched <= 1'b1;
                end
                if (limit_trip) begin
                    clamped <= 1'b1;
                end
                ramp_div <= ramp_tick ? '0 : ramp_div + RAMP_W'(1);
                ramp_one <= next_ramp_one;
                ramp_two <= next_ramp_two;
            end
        end
    end

    // ==================================================
    // per-led current selection
    wire flash_mode = (mode_field == MODE_FLASH) && flash_active;
    wire [CUR_W-1:0] torch_one = led_one_torch_current[CURRENT_LSB +: CUR_W];
    wire [CUR_W-1:0] torch_two = led_two_torch_current[CURRENT_LSB +: CUR_W];
    wire [CUR_W-1:0] five_v_one = (mode_field == MODE_FIXED_5V_TORCH && torch_level)
                                  ? torch_one : LOW_LEVEL_CODE;
    wire [CUR_W-1:0] five_v_two = (mode_field == MODE_FIXED_5V_TORCH && torch_level)
                                  ? torch_two : LOW_LEVEL_CODE;
    wire [CUR_W-1:0] next_led_one = !led_one_en ? CUR_ZERO
                                    : mode_5v ? five_v_one
                                    : flash_mode ? ramp_one : CUR_ZERO;
    wire [CUR_W-1:0] next_led_two = !led_two_en ? CUR_ZERO
                                    : mode_5v ? five_v_two
                                    : flash_mode ? ramp_two : CUR_ZERO;
    wire next_boost = (mode_field != MODE_STANDBY);
    wire next_low_freq = foldback_en && vin_near && next_boost;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regulate_5v <= 1'b0;
            boost_enable <= 1'b0;
            low_frequency <= 1'b0;
            led_one_current <= CUR_ZERO;
            led_two_current <= CUR_ZERO;
            low_battery_threshold <= THRESHOLD_OFF;
            dc_limit_enable <= 1'b0;
            dc_limit_level <= RST_EXTRA_FEATURES[DC_LEVEL_LSB +: 3];
        end else begin
            regulate_5v <= mode_5v;
            boost_enable <= next_boost;
            low_frequency <= next_low_freq;
            led_one_current <= next_led_one;
            led_two_current <= next_led_two;
            low_battery_threshold <= threshold;
            dc_limit_enable <= dc_en;
            dc_limit_level <= dc_level;
        end
    end

    // ==================================================
    // register write and read
    wire wr_mode = reg_write && (reg_addr == ADDR_OUTPUT_MODE);
    wire wr_extra = reg_write && (reg_addr == ADDR_EXTRA_FEATURES);
    wire wr_thr = reg_write && (reg_addr == ADDR_LOWBAT_THR_WIN);
    wire wr_lbc = reg_write && (reg_addr == ADDR_LOWBAT_CURRENT);
    wire wr_f1 = reg_write && (reg_addr == ADDR_LED_ONE_FLASH);
    wire wr_t1 = reg_write && (reg_addr == ADDR_LED_ONE_TORCH);
    wire wr_f2 = reg_write && (reg_addr == ADDR_LED_TWO_FLASH);
    wire wr_t2 = reg_write && (reg_addr == ADDR_LED_TWO_TORCH);
    wire wr_en = reg_write && (reg_addr == ADDR_LED_ENABLES);
    wire rd_fault = reg_read && (reg_addr == ADDR_FAULT_INFO);
    // flag stays while the ramp is still held by the limit
    wire dc_cond = clamped || limit_trip;
    wire next_dc_flag = limit_trip ? 1'b1
                        : (rd_fault && !dc_cond) ? 1'b0
                        : fault_information[DC_FLAG_BIT];

    logic [7:0] read_mux;
    always_comb begin
        if (reg_addr == ADDR_OUTPUT_MODE) begin
            read_mux = output_mode_control;
        end else if (reg_addr == ADDR_EXTRA_FEATURES) begin
            read_mux = extra_features_control;
        end else if (reg_addr == ADDR_LOWBAT_THR_WIN) begin
            read_mux = low_battery_threshold_window;
        end else if (reg_addr == ADDR_LOWBAT_CURRENT) begin
            read_mux = low_battery_current_level;
        end else if (reg_addr == ADDR_LED_ONE_FLASH) begin
            read_mux = led_one_flash_current;
        end else if (reg_addr == ADDR_LED_ONE_TORCH) begin
            read_mux = led_one_torch_current;
        end else if (reg_addr == ADDR_LED_TWO_FLASH) begin
            read_mux = led_two_flash_current;
        end else if (reg_addr == ADDR_LED_TWO_TORCH) begin
            read_mux = led_two_torch_current;
        end else if (reg_addr == ADDR_FAULT_INFO) begin
            read_mux = fault_information;
        end else if (reg_addr == ADDR_LED_ONE_ACTUAL) begin
            read_mux = led_one_actual_current;
        end else if (reg_addr == ADDR_LED_TWO_ACTUAL) begin
            read_mux = led_two_actual_current;
        end else if (reg_addr == ADDR_LED_ENABLES) begin
            read_mux = led_output_enables;
        end else begin
            read_mux = RST_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            output_mode_control <= RST_OUTPUT_MODE;
            extra_features_control <= RST_EXTRA_FEATURES;
            low_battery_threshold_window <= RST_LOWBAT_THR_WIN;
            low_battery_current_level <= RST_ZERO;
            led_one_flash_current <= RST_ZERO;
            led_one_torch_current <= RST_ZERO;
            led_two_flash_current <= RST_ZERO;
            led_two_torch_current <= RST_ZERO;
            fault_information <= RST_ZERO;
            led_one_actual_current <= RST_ZERO;
            led_two_actual_current <= RST_ZERO;
            led_output_enables <= RST_ZERO;
            reg_rdata <= RST_ZERO;
        end else begin
            if (wr_mode) output_mode_control <= reg_wdata;
            if (wr_extra) extra_features_control <= reg_wdata;
            if (wr_thr) low_battery_threshold_window <= reg_wdata;
            if (wr_lbc) low_battery_current_level <= reg_wdata;
            if (wr_f1) led_one_flash_current <= reg_wdata;
            if (wr_t1) led_one_torch_current <= reg_wdata;
            if (wr_f2) led_two_flash_current <= reg_wdata;
            if (wr_t2) led_two_torch_current <= reg_wdata;
            if (wr_en) led_output_enables <= reg_wdata;
            fault_information[DC_FLAG_BIT] <= next_dc_flag;
            if (limit_trip) begin
                // reached level, not the programmed one
                led_one_actual_current <= {2'b00, ramp_one};
                led_two_actual_current <= {2'b00, ramp_two};
            end
            if (reg_read) begin
                reg_rdata <= read_mux;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/flash_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module flash_ctrl_monitor
    import flash_ctrl_pkg::*;
#(
    parameter int CYC_PER_MS = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // controls
    input wire logic regulate_5v,
    input wire logic boost_enable,
    input wire logic low_frequency,
    input wire logic [2:0] low_battery_threshold,
    input wire logic dc_limit_enable,
    input wire logic [2:0] dc_limit_level
);
    // ==========
    // decode
    wire logic wr_mode = reg_write && reg_addr == ADDR_OUTPUT_MODE;
    wire logic wr_feat = reg_write && reg_addr == ADDR_EXTRA_FEATURES;
    wire logic wr_thr = reg_write && reg_addr == ADDR_LOWBAT_THR_WIN;
    // foldback bit as last written, so the gate check is not circular
    logic fb_shadow;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fb_shadow <= RST_EXTRA_FEATURES[FOLDBACK_BIT];
        end else if (wr_feat) begin
            fb_shadow <= reg_wdata[FOLDBACK_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========
    // checks
    a_fixed_rail_on: assert property (
        wr_mode && reg_wdata[2:0] == 3'h1 |-> ##2 regulate_5v && boost_enable)
        else $error("fixed mode did not regulate");
    a_standby_stop: assert property (
        wr_mode && reg_wdata[2:0] == 3'h0 |-> ##2 !regulate_5v && !boost_enable)
        else $error("standby still regulating");
    a_foldback_gate: assert property (
        low_frequency |-> boost_enable && $past(fb_shadow))
        else $error("foldback while disabled or converter off");
    a_dc_enable_copy: assert property (
        wr_feat |-> ##2 dc_limit_enable == $past(reg_wdata[0], 2))
        else $error("dc limit enable wrong");
    a_dc_level_copy: assert property (
        wr_feat |-> ##2 dc_limit_level == $past(reg_wdata[3:1], 2))
        else $error("dc limit level wrong");
    a_threshold_copy: assert property (
        wr_thr |-> ##2 low_battery_threshold == $past(reg_wdata[2:0], 2))
        else $error("threshold wrong");
    a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without read");
    // checked while reset is low, so the default disable is overridden
    a_reset_level: assert property (
        disable iff (1'b0) !rstn |-> dc_limit_level == 3'b100 && !boost_enable)
        else $error("reset state wrong");
    cover property (wr_mode ##2 regulate_5v);
    cover property (low_frequency);
    cover property (reg_read && reg_addr == ADDR_FAULT_INFO ##1 reg_rdata[0]);
endmodule
bind flash_boost_mode_ctrl flash_ctrl_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_i (
    .clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .regulate_5v(regulate_5v), .boost_enable(boost_enable),
    .low_frequency(low_frequency), .low_battery_threshold(low_battery_threshold),
    .dc_limit_enable(dc_limit_enable), .dc_limit_level(dc_limit_level));
`default_nettype wire

// ### verif/flash_host.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // one strobe per call; the next call waits a fresh edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### verif/flash_boost_mode_and_limit_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_boost_mode_and_limit_control_test;
    import flash_ctrl_pkg::*;
    logic clk, rstn, flash_active, torch_pin, low_battery_cmp, dc_limit_cmp, vin_near_boosted_output_rail_cmp;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_write, reg_read, regulate_5v, boost_enable, low_frequency, dc_limit_enable;
    logic [CUR_W-1:0] led_one_current, led_two_current;
    logic [2:0] low_battery_threshold, dc_limit_level;
    int errors, check_count;
    flash_host flash_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    // short millisecond keeps the window tests brief
    flash_boost_mode_ctrl #(.CYC_PER_MS(20)) flash_boost_mode_ctrl_i (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .flash_active(flash_active), .torch_pin(torch_pin),
        .low_battery_cmp(low_battery_cmp), .dc_limit_cmp(dc_limit_cmp),
        .vin_near_boosted_output_rail_cmp(vin_near_boosted_output_rail_cmp), .regulate_5v(regulate_5v),
        .boost_enable(boost_enable), .low_frequency(low_frequency),
        .led_one_current(led_one_current), .led_two_current(led_two_current),
        .low_battery_threshold(low_battery_threshold), .dc_limit_enable(dc_limit_enable),
        .dc_limit_level(dc_limit_level));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========
    // helpers
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // samples on the falling edge, clear of the launching edge
    task ticks(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        flash_host_i.rd(a, d);
        chk("rdata", e, d);
    endtask
    task cur2(input logic [5:0] e1, input logic [5:0] e2);
        chk("led_one", {2'b00, e1}, {2'b00, led_one_current});
        chk("led_two", {2'b00, e2}, {2'b00, led_two_current});
    endtask
    task flash(input logic [7:0] fl);
        flash_host_i.wr(ADDR_LED_ONE_FLASH, fl);
        flash_host_i.wr(ADDR_LED_TWO_FLASH, fl);
        flash_host_i.wr(ADDR_OUTPUT_MODE, 8'h03);
        flash_host_i.wr(ADDR_LED_ENABLES, 8'h03);
        @(posedge clk) flash_active <= 1'b1;
    endtask
    task stop;
        @(posedge clk);
        flash_active <= 1'b0;
        dc_limit_cmp <= 1'b0;
        low_battery_cmp <= 1'b0;
        ticks(8);
    endtask
    task wait_cur(input logic [5:0] e);
        for (int i = 0; i < 4000 && led_one_current !== e; i++) @(negedge clk);
        chk("wait_cur", {2'b00, e}, {2'b00, led_one_current});
    endtask
    // ==========
    // scenarios
    task reset_values;
        rchk(ADDR_OUTPUT_MODE, 8'h00);
        rchk(ADDR_EXTRA_FEATURES, 8'h88);
        rchk(ADDR_LOWBAT_THR_WIN, 8'h18);
        rchk(8'h02, 8'h00);
    endtask
    task fixed_rail;
        flash_host_i.wr(ADDR_LED_ENABLES, 8'h03);
        flash_host_i.wr(ADDR_OUTPUT_MODE, 8'h01);
        ticks(2);
        chk("regulate", 8'h01, {7'h00, regulate_5v});
        cur2(LOW_LEVEL_CODE, LOW_LEVEL_CODE);
        @(posedge clk) vin_near_boosted_output_rail_cmp <= 1'b1;
        ticks(8);
        chk("low_freq", 8'h00, {7'h00, low_frequency});
        flash_host_i.wr(ADDR_EXTRA_FEATURES, 8'h1F);
        ticks(2);
        chk("low_freq", 8'h01, {7'h00, low_frequency});
        chk("dc_level", 8'h07, {5'h00, dc_limit_level});
        chk("dc_en", 8'h01, {7'h00, dc_limit_enable});
        @(posedge clk) vin_near_boosted_output_rail_cmp <= 1'b0;
        ticks(8);
        chk("low_freq", 8'h00, {7'h00, low_frequency});
        flash_host_i.wr(ADDR_OUTPUT_MODE, 8'h00);
        ticks(2);
        chk("boost", 8'h00, {6'h00, boost_enable, regulate_5v});
    endtask
    task torch_mode;
        flash_host_i.wr(ADDR_LED_ENABLES, 8'h00);
        flash_host_i.wr(ADDR_OUTPUT_MODE, 8'h06);
        flash_host_i.wr(ADDR_LED_ENABLES, 8'h03);
        flash_host_i.wr(ADDR_LED_ONE_TORCH, 8'h15);
        flash_host_i.wr(ADDR_LED_TWO_TORCH, 8'h2A);
        @(posedge clk) torch_pin <= 1'b1;
        ticks(8);
        cur2(6'h15, 6'h2A);
        @(posedge clk) torch_pin <= 1'b0;
        ticks(8);
        cur2(LOW_LEVEL_CODE, LOW_LEVEL_CODE);
        flash_host_i.wr(ADDR_LED_ENABLES, 8'h01);
        ticks(2);
        cur2(LOW_LEVEL_CODE, CUR_ZERO);
    endtask
    task full_flash;
        flash(8'h03);
        wait_cur(6'h03);
        ticks(1000);
        cur2(6'h03, 6'h03);
        rchk(ADDR_FAULT_INFO, 8'h00);
        stop;
    endtask
    task dc_limit;
        flash(8'h05);
        wait_cur(6'h02);
        @(posedge clk) dc_limit_cmp <= 1'b1;
        ticks(2000);
        cur2(6'h02, 6'h02);
        rchk(ADDR_FAULT_INFO, 8'h01);
        flash_host_i.wr(ADDR_LED_ONE_ACTUAL, 8'hFF);
        rchk(ADDR_LED_ONE_ACTUAL, 8'h02);
        rchk(ADDR_LED_TWO_ACTUAL, 8'h02);
        rchk(ADDR_FAULT_INFO, 8'h01);
        stop;
        rchk(ADDR_FAULT_INFO, 8'h01);
        rchk(ADDR_FAULT_INFO, 8'h00);
    endtask
    task low_battery;
        flash_host_i.wr(ADDR_LOWBAT_THR_WIN, 8'h09);
        ticks(2);
        chk("threshold", 8'h01, {5'h00, low_battery_threshold});
        flash_host_i.wr(ADDR_LOWBAT_CURRENT, 8'h01);
        @(posedge clk) low_battery_cmp <= 1'b1;
        flash(8'h03);
        ticks(3000);
        cur2(CUR_ONE, CUR_ONE);
        @(posedge clk) low_battery_cmp <= 1'b0;
        ticks(1000);
        cur2(CUR_ONE, CUR_ONE);
        stop;
    endtask
    task late_lowbat(input logic [7:0] win, input logic [5:0] e);
        flash_host_i.wr(ADDR_LOWBAT_THR_WIN, win);
        flash(8'h03);
        ticks(200);
        @(posedge clk) low_battery_cmp <= 1'b1;
        ticks(3000);
        cur2(e, e);
        stop;
    endtask
    initial begin
        rstn = 1'b1;
        flash_active = 1'b0;
        torch_pin = 1'b0;
        low_battery_cmp = 1'b0;
        dc_limit_cmp = 1'b0;
        vin_near_boosted_output_rail_cmp = 1'b0;
        errors = 0;
        check_count = 0;
        // reset edge after time zero so every flop is sure to see it
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        reset_values;
        fixed_rail;
        torch_mode;
        full_flash;
        dc_limit;
        low_battery;
        late_lowbat(8'h09, 6'h03);
        late_lowbat(8'h01, CUR_ONE);
        end_sim;
    end
    initial begin
        #1000000;
        errors++;
        end_sim;
    end
endmodule
`default_nettype wire
